//--- fault_ext_defines.vh
// register offsets, field positions, reset values and commands of the fault status block
`ifndef FAULT_EXT_DEFINES_VH
`define FAULT_EXT_DEFINES_VH

// printed offsets are register indices; byte address is index times four
`define IDX_FAULT_E_SOURCE_CONFIG       4'h0
`define IDX_FAULT_A_ACTION_CONFIG       4'h1
`define IDX_FAULT_A_INPUT_CONDITIONING  4'h2
`define IDX_FAULT_B_ACTION_CONFIG       4'h3
`define IDX_FAULT_B_INPUT_CONDITIONING  4'h4
`define IDX_FAULT_STATE_STATUS          4'h5
`define IDX_FAULT_CLEAR_COMMANDS        4'h6
`define IDX_FAULT_SET_COMMANDS          4'h7
`define IDX_RAMP_MODE_CONFIG            4'h8

// fault_b_input_conditioning fields
`define QUALIFY_BIT      0
`define BLANKING_BIT     1
`define FILTER_BIT       2
// action config: software mode bit and halt field
`define SOFT_MODE_BIT    7
`define HALT_LSB         5
`define HALT_SW          2'h2

// status fields
`define E_LIVE_BIT       0
`define A_LIVE_BIT       1
`define B_LIVE_BIT       2
`define CYCLE_IDX_BIT    3
`define E_STATE_BIT      5
`define A_STATE_BIT      6
`define B_STATE_BIT      7

// clear and set command fields
`define E_CLR_BIT        5
`define A_CLR_BIT        6
`define B_CLR_BIT        7
`define E_FORCE_BIT      5
`define A_FORCE_BIT      6
`define B_FORCE_BIT      7
`define IDX_CMD_LSB      3

// cycle index commands
`define IDX_CMD_TOGGLE   2'h0
`define IDX_CMD_SET      2'h1
`define IDX_CMD_CLEAR    2'h2
`define IDX_CMD_HOLD     2'h3

// ramp mode values in the ramp mode register
`define RAMP_SINGLE      1'b0
`define RAMP_DUAL        1'b1

`define REG_RESET        8'h00
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

//--- fault_ext_properties.sv
// port-level checks for the fault status and command block
`timescale 1ns/100ps
module fault_ext_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        chan_raw,
  input wire        chan_filtered,
  input wire        fault_b_cond,
  input wire        timer_update,
  input wire        fault_b_source,
  input wire        fault_b_blank_en,
  input wire        fault_b_qualify_en,
  input wire        first_fault_force,
  input wire        external_fault_force,
  input wire        first_halt_release,
  input wire        second_halt_release,
  input wire        timer_resume,
  input wire        timer_error_set,
  input wire        cycle_index_bit
);
  wire       wr_go, ext_set, ramp_wr;
  wire [3:0] widx;
  // bench offers aw and w together, so one edge takes both
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready && s_axi_wstrb[0];
  assign widx = s_axi_awaddr[5:2];
  assign ext_set = wr_go && widx == 4'h7 && s_axi_wdata[5];
  assign ramp_wr = wr_go && widx == 4'h8;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_cond_bits: assert property (
    wr_go && widx == 4'h4 |=> fault_b_blank_en == $past(s_axi_wdata[1]) &&
    fault_b_qualify_en == $past(s_axi_wdata[0]))
    else $error("enable bits wrong");
  a_src_pick: assert property (
    wr_go && widx == 4'h4 |=> fault_b_source ==
    ($past(s_axi_wdata[2]) ? chan_filtered : chan_raw))
    else $error("wrong fault B source");
  a_first_force: assert property (
    wr_go && widx == 4'h7 && s_axi_wdata[6] |=>
    first_fault_force ##1 !first_fault_force)
    else $error("force not one cycle");
  a_ext_cause: assert property (
    external_fault_force |-> $past(ext_set))
    else $error("force without write");
  a_index_still: assert property (
    !timer_update && !ramp_wr && !$past(ramp_wr) |=>
    $stable(cycle_index_bit))
    else $error("index moved early");
  a_err_cause: assert property (
    timer_error_set |-> $past(fault_b_cond, 2) ||
    $past(fault_b_cond, 3) || $past(fault_b_cond, 4))
    else $error("error flag without fault");
  a_halt_pulse: assert property (
    first_halt_release || second_halt_release |=>
    !first_halt_release && !second_halt_release)
    else $error("halt release too long");
  a_resume_pulse: assert property (
    timer_resume |=> !timer_resume [*2])
    else $error("counter resume repeated");
endmodule

bind fault_extension_status_control fault_ext_properties chk_i (.*);

//--- fault_extension_status_control.v
// fault extension status, clear and set registers behind an AXI4-Lite slave
//
// Function
// - filter select picks filtered channel as fault B source.
// - blanking bit enables input blanking on fault B.
// - qualify bit enables fault B qualification, else bypassed.
// - fault B state set on condition, cleared when fault A action done.
// - fault A state set on condition, cleared when fault B action done.
// - fault E state set on condition, cleared when its action completes.
// - cycle index reads zero in cycle A, one in B, zero in single ramp.
// - live A and B flags follow their fault conditions through the two-flop synchroniser.
// - live E flag high while condition present, low when gone.
// - state-B clear clears state once live B low; releases software halt.
// - state-A clear clears state once live A low; releases software halt.
// - state-E clear clears state once live E low; counter resumes.
// - latched B flag set on event in software mode; write one clears.
// - latched A flag set on event in software mode; write one clears.
// - latched E flag set on every E event; write one clears.
// - software force bits force a fault, self-clear next cycle.
// - index command 00 toggle, 01 force B, 10 force A, 11 hold.
// - index command acts at counter update, then self-clears.
// - fault B detection in software mode sets counter error flag.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "fault_ext_defines.vh"

module fault_extension_status_control (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        chan_raw,
  input  wire        chan_filtered,
  input  wire        fault_a_cond,
  input  wire        fault_e_cond,
  input  wire        fault_a_action_done,
  input  wire        fault_b_action_done,
  input  wire        fault_e_action_done,
  input  wire        timer_update,
  output wire        fault_b_source,
  output wire        fault_b_blank_en,
  output wire        fault_b_qualify_en,
  input  wire        fault_b_cond,
  output reg         first_fault_force,
  output reg         second_fault_force,
  output reg         external_fault_force,
  output reg         first_halt_release,
  output reg         second_halt_release,
  output reg         timer_resume,
  output reg         timer_error_set,
  output wire        cycle_index_bit
);

  reg  [7:0] e_cfg_ff;
  reg  [7:0] a_cfg_ff;
  reg  [7:0] a_cond_cfg_ff;
  reg  [7:0] b_cfg_ff;
  reg  [7:0] b_cond_cfg_ff;
  reg        ramp_mode_ff;
  reg  [2:0] live_s1_ff;
  reg  [2:0] live_s2_ff;
  reg  [2:0] live_d_ff;
  reg        first_fault_state_ff;
  reg        second_fault_state_ff;
  reg        external_fault_state_ff;
  reg        first_clr_pend_ff;
  reg        second_clr_pend_ff;
  reg        ext_clr_pend_ff;
  reg        first_latched_ff;
  reg        second_latched_ff;
  reg        external_latched_ff;
  reg  [1:0] cycle_index_command_ff;
  reg        idx_ff;
  reg  [3:0] wr_idx_ff;
  reg  [7:0] wr_data_ff;
  reg        aw_held_ff;
  reg        w_held_ff;
  reg        wr_strb_ff;

  wire       first_fault_live_flag;
  wire       second_fault_live_flag;
  wire       external_fault_live_flag;
  wire       first_evt;
  wire       second_evt;
  wire       external_evt;
  wire       wr_go;
  wire [3:0] wr_idx;
  wire [7:0] wr_data;
  wire       wr_ok;
  wire       clr_wr;
  wire       set_wr;
  wire [3:0] rd_idx;
  wire [7:0] status_byte;
  reg  [7:0] rd_byte;
  reg        nxt_idx;

  // fault B source conditioning selections
  assign fault_b_source     = b_cond_cfg_ff[`FILTER_BIT] ?
                              chan_filtered : chan_raw;
  assign fault_b_blank_en   = b_cond_cfg_ff[`BLANKING_BIT];
  assign fault_b_qualify_en = b_cond_cfg_ff[`QUALIFY_BIT];

  // conditions come from asynchronous sources, so two flops before use
  always @(posedge aclk) begin
    if (!aresetn) begin
      live_s1_ff <= 3'h0;
      live_s2_ff <= 3'h0;
      live_d_ff  <= 3'h0;
    end else begin
      live_s1_ff <= {fault_b_cond, fault_a_cond, fault_e_cond};
      live_s2_ff <= live_s1_ff;
      live_d_ff  <= live_s2_ff;
    end
  end

  // a software force counts as a one-cycle fault condition
  assign external_fault_live_flag = live_s2_ff[0] | external_fault_force;
  assign first_fault_live_flag    = live_s2_ff[1] | first_fault_force;
  assign second_fault_live_flag   = live_s2_ff[2] | second_fault_force;
  assign external_evt = (live_s2_ff[0] & ~live_d_ff[0]) | external_fault_force;
  assign first_evt    = (live_s2_ff[1] & ~live_d_ff[1]) | first_fault_force;
  assign second_evt   = (live_s2_ff[2] & ~live_d_ff[2]) | second_fault_force;

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
  assign wr_go   = (aw_held_ff | (s_axi_awvalid & s_axi_awready)) &
                   (w_held_ff | (s_axi_wvalid & s_axi_wready));
  assign wr_idx  = aw_held_ff ? wr_idx_ff : s_axi_awaddr[5:2];
  assign wr_data = w_held_ff ? wr_data_ff : s_axi_wdata[7:0];
  assign wr_ok   = wr_go & (w_held_ff ? wr_strb_ff : s_axi_wstrb[0]);
  assign clr_wr  = wr_ok & (wr_idx == `IDX_FAULT_CLEAR_COMMANDS);
  assign set_wr  = wr_ok & (wr_idx == `IDX_FAULT_SET_COMMANDS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      wr_idx_ff    <= 4'h0;
      wr_data_ff   <= `REG_RESET;
      wr_strb_ff   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx > `IDX_RAMP_MODE_CONFIG) ?
                        `RESP_SLVERR : `RESP_OKAY;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_held_ff <= 1'b1;
          wr_idx_ff  <= s_axi_awaddr[5:2];
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_held_ff  <= 1'b1;
          wr_data_ff <= s_axi_wdata[7:0];
          wr_strb_ff <= s_axi_wstrb[0];
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // configuration registers; status is read-only
  always @(posedge aclk) begin
    if (!aresetn) begin
      e_cfg_ff      <= `REG_RESET;
      a_cfg_ff      <= `REG_RESET;
      a_cond_cfg_ff <= `REG_RESET;
      b_cfg_ff      <= `REG_RESET;
      b_cond_cfg_ff <= `REG_RESET;
      ramp_mode_ff  <= `RAMP_SINGLE;
    end else if (wr_ok) begin
      case (wr_idx)
        `IDX_FAULT_E_SOURCE_CONFIG:      e_cfg_ff      <= wr_data;
        `IDX_FAULT_A_ACTION_CONFIG:      a_cfg_ff      <= wr_data;
        // reserved bits held at zero
        `IDX_FAULT_A_INPUT_CONDITIONING: a_cond_cfg_ff <= wr_data & 8'h27;
        `IDX_FAULT_B_ACTION_CONFIG:      b_cfg_ff      <= wr_data & 8'hFB;
        `IDX_FAULT_B_INPUT_CONDITIONING: b_cond_cfg_ff <= wr_data & 8'h27;
        `IDX_RAMP_MODE_CONFIG:           ramp_mode_ff  <= wr_data[0];
        default: ;
      endcase
    end
  end

  // fault states: set wins over hardware or software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_fault_state_ff    <= 1'b0;
      second_fault_state_ff   <= 1'b0;
      external_fault_state_ff <= 1'b0;
      first_clr_pend_ff       <= 1'b0;
      second_clr_pend_ff      <= 1'b0;
      ext_clr_pend_ff         <= 1'b0;
      first_halt_release      <= 1'b0;
      second_halt_release     <= 1'b0;
      timer_resume            <= 1'b0;
    end else begin
      // a clear command waits for the live flag to drop
      first_clr_pend_ff  <= (first_clr_pend_ff | (clr_wr &
                            wr_data[`A_CLR_BIT])) & first_fault_live_flag;
      second_clr_pend_ff <= (second_clr_pend_ff | (clr_wr &
                            wr_data[`B_CLR_BIT])) & second_fault_live_flag;
      ext_clr_pend_ff    <= (ext_clr_pend_ff | (clr_wr &
                            wr_data[`E_CLR_BIT])) & external_fault_live_flag;
      first_halt_release  <= 1'b0;
      second_halt_release <= 1'b0;
      timer_resume        <= 1'b0;
      if (first_fault_live_flag)
        first_fault_state_ff <= 1'b1;
      else if (fault_b_action_done)
        first_fault_state_ff <= 1'b0;
      else if ((first_clr_pend_ff | (clr_wr & wr_data[`A_CLR_BIT]))) begin
        first_fault_state_ff <= 1'b0;
        first_halt_release   <= (a_cfg_ff[6:5] == `HALT_SW);
      end
      if (second_fault_live_flag)
        second_fault_state_ff <= 1'b1;
      else if (fault_a_action_done)
        second_fault_state_ff <= 1'b0;
      else if ((second_clr_pend_ff | (clr_wr & wr_data[`B_CLR_BIT]))) begin
        second_fault_state_ff <= 1'b0;
        second_halt_release   <= (b_cfg_ff[6:5] == `HALT_SW);
      end
      if (external_fault_live_flag)
        external_fault_state_ff <= 1'b1;
      else if (fault_e_action_done)
        external_fault_state_ff <= 1'b0;
      else if ((ext_clr_pend_ff | (clr_wr & wr_data[`E_CLR_BIT]))) begin
        // resumes from last count; a restart beforehand is software's job
        external_fault_state_ff <= 1'b0;
        timer_resume            <= 1'b1;
      end
    end
  end

  // latched flags, write one to clear, event wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_latched_ff    <= 1'b0;
      second_latched_ff   <= 1'b0;
      external_latched_ff <= 1'b0;
      timer_error_set     <= 1'b0;
    end else begin
      second_latched_ff <= (second_evt & b_cfg_ff[`SOFT_MODE_BIT]) |
                           (second_latched_ff &
                            ~(clr_wr & wr_data[`B_LIVE_BIT]));
      first_latched_ff  <= (first_evt & a_cfg_ff[`SOFT_MODE_BIT]) |
                           (first_latched_ff &
                            ~(clr_wr & wr_data[`A_LIVE_BIT]));
      external_latched_ff <= external_evt |
                             (external_latched_ff &
                              ~(clr_wr & wr_data[`E_LIVE_BIT]));
      timer_error_set <= second_evt & b_cfg_ff[`SOFT_MODE_BIT];
    end
  end

  // software force bits last one cycle; index command waits for update
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_fault_force      <= 1'b0;
      second_fault_force     <= 1'b0;
      external_fault_force   <= 1'b0;
      cycle_index_command_ff <= `IDX_CMD_TOGGLE;
      idx_ff                 <= 1'b0;
    end else begin
      first_fault_force    <= set_wr & wr_data[`A_FORCE_BIT];
      second_fault_force   <= set_wr & wr_data[`B_FORCE_BIT];
      external_fault_force <= set_wr & wr_data[`E_FORCE_BIT];
      idx_ff <= nxt_idx;
      if (timer_update)
        cycle_index_command_ff <= `IDX_CMD_TOGGLE;
      else if (set_wr)
        cycle_index_command_ff <= wr_data[`IDX_CMD_LSB+1:`IDX_CMD_LSB];
    end
  end

  always @* begin
    nxt_idx = idx_ff;
    if (ramp_mode_ff != `RAMP_DUAL) begin
      nxt_idx = 1'b0;
    end else if (timer_update) begin
      case (cycle_index_command_ff)
        `IDX_CMD_TOGGLE: nxt_idx = ~idx_ff;
        `IDX_CMD_SET:    nxt_idx = 1'b1;
        `IDX_CMD_CLEAR:  nxt_idx = 1'b0;
        `IDX_CMD_HOLD:   nxt_idx = idx_ff;
        default:         nxt_idx = idx_ff;
      endcase
    end
  end

  assign cycle_index_bit = idx_ff;
  assign status_byte = {second_fault_state_ff, first_fault_state_ff,
                        external_fault_state_ff, 1'b0, idx_ff,
                        second_fault_live_flag, first_fault_live_flag,
                        external_fault_live_flag};

  // AXI4-Lite read: one outstanding read at a time
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = s_axi_araddr[5:2];

  always @* begin
    case (rd_idx)
      `IDX_FAULT_E_SOURCE_CONFIG:      rd_byte = e_cfg_ff;
      `IDX_FAULT_A_ACTION_CONFIG:      rd_byte = a_cfg_ff;
      `IDX_FAULT_A_INPUT_CONDITIONING: rd_byte = a_cond_cfg_ff;
      `IDX_FAULT_B_ACTION_CONFIG:      rd_byte = b_cfg_ff;
      `IDX_FAULT_B_INPUT_CONDITIONING: rd_byte = b_cond_cfg_ff;
      `IDX_FAULT_STATE_STATUS:         rd_byte = status_byte;
      `IDX_FAULT_CLEAR_COMMANDS:       rd_byte = {5'h00, second_latched_ff,
                                         first_latched_ff,
                                         external_latched_ff};
      `IDX_FAULT_SET_COMMANDS:         rd_byte = {second_fault_force,
                                          first_fault_force,
                                          external_fault_force,
                                          cycle_index_command_ff, 3'h0};
      `IDX_RAMP_MODE_CONFIG:           rd_byte = {7'h00, ramp_mode_ff};
      default:                         rd_byte = 8'h00;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= (rd_idx > `IDX_RAMP_MODE_CONFIG) ?
                      `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- fault_extension_status_control_test.sv
// self-checking bench for the fault status and command registers
`timescale 1ns/100ps
module fault_extension_status_control_test;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [5:0]  awaddr = 6'h00;
  reg  [31:0] wdata = 32'h00000000;
  reg  [3:0]  wstrb = 4'hF;
  reg  [5:0]  araddr = 6'h00;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        raw, filt, ca, cb, ce, da, db, de, upd, src, blank, qual, cyc;
  wire [6:0]  pulses;
  reg  [6:0]  seen = 7'h00;
  reg  [7:0]  rd;
  integer     err_count = 0;
  integer     n_compared = 0;

  fault_extension_status_control uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_raw(raw), .chan_filtered(filt),
    .fault_a_cond(ca), .fault_e_cond(ce), .fault_a_action_done(da),
    .fault_b_action_done(db), .fault_e_action_done(de),
    .timer_update(upd), .fault_b_source(src), .fault_b_blank_en(blank),
    .fault_b_qualify_en(qual), .fault_b_cond(cb),
    .first_fault_force(pulses[0]), .second_fault_force(pulses[1]),
    .external_fault_force(pulses[2]), .first_halt_release(pulses[3]),
    .second_halt_release(pulses[4]), .timer_resume(pulses[5]),
    .timer_error_set(pulses[6]), .cycle_index_bit(cyc));
  fault_far_side far (
    .aclk(aclk), .chan_raw(raw), .chan_filtered(filt), .fault_a_cond(ca),
    .fault_b_cond(cb), .fault_e_cond(ce), .fault_a_action_done(da),
    .fault_b_action_done(db), .fault_e_action_done(de),
    .timer_update(upd));

  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    seen <= seen | pulses;
  end

  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("BAD %s expected %h seen %h", what, exp, got);
        err_count = err_count + 1;
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d, mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task stuck;
    begin
      $display("BAD bus answer expected 1 seen 0");
      err_count = err_count + 1;
      wrap_up;
    end
  endtask
  // ready and valid are read mid-cycle; the next rise is the taking edge
  task wr(input [3:0] idx, input [7:0] d, input [1:0] resp);
    integer   n;
    reg       a_hit, w_hit, done;
    reg [1:0] br;
    begin
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n = n + 1) begin
        @(negedge aclk);
        a_hit = awvalid && awready;
        w_hit = wvalid && wready;
        done = bvalid;
        br = bresp;
        @(posedge aclk);
        if (a_hit)
          awvalid <= 1'b0;
        if (w_hit)
          wvalid <= 1'b0;
        if (done)
          bready <= 1'b0;
      end
      if (!done)
        stuck;
      chk("write resp", {6'h00, resp}, {6'h00, br});
    end
  endtask
  task rd_reg(input [3:0] idx, input [1:0] resp, output [7:0] d);
    integer   n;
    reg       hit, done;
    reg [1:0] rr;
    begin
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n = n + 1) begin
        @(negedge aclk);
        hit = arvalid && arready;
        done = rvalid;
        d = rdata[7:0];
        rr = rresp;
        @(posedge aclk);
        if (hit)
          arvalid <= 1'b0;
        if (done)
          rready <= 1'b0;
      end
      if (!done)
        stuck;
      chk("read resp", {6'h00, resp}, {6'h00, rr});
    end
  endtask
  task expect_reg(input [3:0] idx, input [7:0] mask, input [7:0] exp);
    begin
      rd_reg(idx, 2'h0, rd);
      chk($sformatf("register %0d", idx), exp, rd & mask);
    end
  endtask
  task st(input [7:0] e);
    begin
      expect_reg(4'h5, 8'hFF, e);
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge aclk);
    end
  endtask
  task clr_seen;
    begin
      @(negedge aclk);
      seen = 7'h00;
    end
  endtask

  task t_reset;
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1)
        expect_reg(i[3:0], 8'hFF, 8'h00);
      rd_reg(4'h9, 2'h2, rd);
      chk("unmapped data", 8'h00, rd);
      wr(4'hF, 8'h5A, 2'h2);
      wstrb <= 4'h0;
      wr(4'h4, 8'h07, 2'h0);
      wstrb <= 4'hF;
      expect_reg(4'h4, 8'hFF, 8'h00);
      $display("reset done");
    end
  endtask
  task t_cond;
    begin
      wr(4'h4, 8'h07, 2'h0);
      far.levels(4'h8);
      @(negedge aclk);
      chk("blank", 8'h01, {7'h00, blank});
      chk("qualify", 8'h01, {7'h00, qual});
      chk("filt source", 8'h01, {7'h00, src});
      far.levels(4'h0);
      @(negedge aclk);
      chk("filt source", 8'h00, {7'h00, src});
      wr(4'h4, 8'h02, 2'h0);
      repeat (2) begin
        @(negedge aclk);
        chk("raw source", {7'h00, raw}, {7'h00, src});
      end
      chk("qualify", 8'h00, {7'h00, qual});
      wr(4'h4, 8'h00, 2'h0);
      @(negedge aclk);
      chk("blank", 8'h00, {7'h00, blank});
      $display("conditioning done");
    end
  endtask
  task t_fault_e;
    begin
      clr_seen;
      far.levels(4'h1);
      settle;
      st(8'h21);
      expect_reg(4'h6, 8'h07, 8'h01);
      // no restart first, so it resumes
      wr(4'h6, 8'h20, 2'h0);
      st(8'h21);
      far.levels(4'h0);
      settle;
      st(8'h00);
      chk("resume", 8'h01, {7'h00, seen[5]});
      far.levels(4'h1);
      settle;
      far.levels(4'h0);
      // live flag lags the pin by the synchroniser, so wait it out
      far.strobe(4'h4, 3);
      settle;
      st(8'h00);
      wr(4'h6, 8'h01, 2'h0);
      expect_reg(4'h6, 8'h07, 8'h00);
      $display("fault E done");
    end
  endtask
  task t_fault_a;
    begin
      far.levels(4'h2);
      settle;
      st(8'h42);
      expect_reg(4'h6, 8'h07, 8'h00);
      far.levels(4'h0);
      settle;
      st(8'h40);
      far.strobe(4'h2, 3);
      st(8'h00);
      wr(4'h1, 8'hC0, 2'h0);
      clr_seen;
      far.levels(4'h2);
      settle;
      far.levels(4'h0);
      settle;
      expect_reg(4'h6, 8'h07, 8'h02);
      wr(4'h6, 8'h40, 2'h0);
      settle;
      st(8'h00);
      chk("halt A release", 8'h01, {7'h00, seen[3]});
      wr(4'h6, 8'h02, 2'h0);
      expect_reg(4'h6, 8'h07, 8'h00);
      wr(4'h1, 8'h00, 2'h0);
      $display("fault A done");
    end
  endtask
  task t_fault_b;
    begin
      wr(4'h3, 8'hC0, 2'h0);
      clr_seen;
      far.levels(4'h4);
      settle;
      st(8'h84);
      expect_reg(4'h6, 8'h07, 8'h04);
      chk("error set", 8'h01, {7'h00, seen[6]});
      far.levels(4'h0);
      settle;
      far.strobe(4'h1, 0);
      st(8'h00);
      far.levels(4'h4);
      settle;
      far.levels(4'h0);
      wr(4'h6, 8'h84, 2'h0);
      settle;
      st(8'h00);
      expect_reg(4'h6, 8'h07, 8'h00);
      chk("halt B release", 8'h01, {7'h00, seen[4]});
      wr(4'h3, 8'h00, 2'h0);
      clr_seen;
      far.levels(4'h4);
      settle;
      far.levels(4'h0);
      settle;
      expect_reg(4'h6, 8'h07, 8'h00);
      chk("error quiet", 8'h00, {7'h00, seen[6]});
      $display("fault B done");
    end
  endtask
  task t_force;
    begin
      clr_seen;
      wr(4'h7, 8'hE0, 2'h0);
      settle;
      chk("force pulses", 8'h07, {5'h00, seen[2:0]});
      expect_reg(4'h7, 8'hFF, 8'h00);
      expect_reg(4'h6, 8'h07, 8'h01);
      wr(4'h6, 8'hE7, 2'h0);
      settle;
      st(8'h00);
      $display("force done");
    end
  endtask
  task t_index;
    reg [9:0] cmds;
    reg [4:0] exps;
    reg       prev;
    integer   i;
    begin
      cmds = {2'h1, 2'h3, 2'h0, 2'h0, 2'h2};
      exps = 5'b11010;
      prev = 1'b0;
      wr(4'h8, 8'h01, 2'h0);
      for (i = 0; i < 5; i = i + 1) begin
        wr(4'h7, {3'h0, cmds[9 - 2 * i -: 2], 3'h0}, 2'h0);
        expect_reg(4'h5, 8'h08, {4'h0, prev, 3'h0});
        far.strobe(4'h8, 0);
        prev = exps[4 - i];
        expect_reg(4'h5, 8'h08, {4'h0, prev, 3'h0});
        expect_reg(4'h7, 8'h18, 8'h00);
      end
      wr(4'h7, 8'h08, 2'h0);
      wr(4'h8, 8'h00, 2'h0);
      far.strobe(4'h8, 0);
      expect_reg(4'h5, 8'h08, 8'h00);
      $display("index done");
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_cond;
    t_fault_e;
    t_fault_a;
    t_fault_b;
    t_force;
    t_index;
    wrap_up;
  end
endmodule

//--- fault_far_side.sv
// far-side model: counter core and fault event channels
`timescale 1ns/100ps
module fault_far_side (
  input  wire aclk,
  output reg  chan_raw = 1'b0,
  output reg  chan_filtered = 1'b0,
  output reg  fault_a_cond = 1'b0,
  output reg  fault_b_cond = 1'b0,
  output reg  fault_e_cond = 1'b0,
  output reg  fault_a_action_done = 1'b0,
  output reg  fault_b_action_done = 1'b0,
  output reg  fault_e_action_done = 1'b0,
  output reg  timer_update = 1'b0
);
  // raw channel toggles every cycle so a wrong source pick cannot hide
  always @(posedge aclk) begin
    chan_raw <= ~chan_raw;
  end
  // levels order: filtered channel, fault B, fault A, fault E
  task levels(input [3:0] v);
    begin
      @(posedge aclk);
      {chan_filtered, fault_b_cond, fault_a_cond, fault_e_cond} <= v;
    end
  endtask
  // one-cycle strobe after dly idle cycles
  task strobe(input [3:0] sel, input integer dly);
    begin
      repeat (dly + 1) @(posedge aclk);
      {timer_update, fault_e_action_done, fault_b_action_done,
       fault_a_action_done} <= sel;
      @(posedge aclk);
      {timer_update, fault_e_action_done, fault_b_action_done,
       fault_a_action_done} <= 4'h0;
    end
  endtask
endmodule
